// File: logic/mcpi_pkg.sv
// constants and types shared by the controller pin interface
package mcpi_pkg;

    // widths of the pin groups
    localparam int PC_W    = 13;
    localparam int INSTR_W = 16;
    localparam int BUS_W   = 8;

    // timing: core clock period and instruction cycle length
    localparam int CLK_PERIOD_NS   = 100;
    localparam int OSC_HALF_NS     = 200;
    localparam int OSC_HALF_CYCLES = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // instruction cycle is one oscillator period split into four quarters
    localparam int QUARTERS        = 4;

    // quarter numbers within one instruction cycle
    localparam logic [1:0] Q_FIRST  = 2'h0;
    localparam logic [1:0] Q_DRIVE  = 2'h1;
    localparam logic [1:0] Q_SAMPLE = 2'h2;
    localparam logic [1:0] Q_LAST   = 2'h3;

    // reset values
    localparam logic [PC_W-1:0]  PC_RESET  = 13'h0000;
    localparam logic [BUS_W-1:0] BUS_RESET = 8'h00;

    // bus operation requested by the execution core for one cycle
    typedef enum logic [1:0] {
        OP_NONE,
        OP_SELECT,
        OP_WRITE,
        OP_READ
    } mcpi_op_t;

    // run state of the instruction sequencer
    typedef enum logic [1:0] {
        ST_RESET,
        ST_RUN,
        ST_HALT
    } mcpi_state_t;

endpackage

// File: logic/mcpi_port_if.sv
// pin interface of the controller: program fetch, port bus, reset and halt
`timescale 1ns/1ps
module mcpi_port_if
    import mcpi_pkg::*;
(
    // clock and reset
    input  logic                 core_clk,
    input  logic                 rst,
    // program storage pins
    output logic [PC_W-1:0]      program_address,
    input  logic [INSTR_W-1:0]   instruction_word,
    // control pins
    input  logic                 reset_pin_n,
    input  logic                 halt_n,
    // port bus pins
    output logic                 port_select_strobe,
    output logic                 write_direction_flag,
    output logic                 left_bank_enable_n,
    output logic                 right_bank_enable_n,
    input  logic [BUS_W-1:0]     peripheral_data_bus_in,
    output logic [BUS_W-1:0]     peripheral_data_bus_out,
    output logic                 peripheral_data_bus_oe,
    output logic                 master_clock,
    // execution core request side
    output logic                 cycle_start,
    input  logic                 core_jump,
    input  logic [PC_W-1:0]      core_jump_addr,
    input  mcpi_op_t             core_op,
    input  logic [BUS_W-1:0]     core_op_data,
    input  logic                 core_left,
    input  logic                 core_right,
    // execution core answer side
    output logic [INSTR_W-1:0]   fetch_word,
    output logic                 fetch_valid,
    output logic [BUS_W-1:0]     read_data,
    output logic                 read_valid,
    output logic                 halted
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // reverse a bus so that the highest-numbered pin is the lsb
    function automatic logic [PC_W-1:0] rev_pc(input logic [PC_W-1:0] v);
        logic [PC_W-1:0] r;
        r = '0;
        for (int i = 0; i < PC_W; i++)
            r[i] = v[PC_W-1-i];
        return r;
    endfunction

    function automatic logic [INSTR_W-1:0] rev_instr(input logic [INSTR_W-1:0] v);
        logic [INSTR_W-1:0] r;
        r = '0;
        for (int i = 0; i < INSTR_W; i++)
            r[i] = v[INSTR_W-1-i];
        return r;
    endfunction

    // byte to and from bus lines: low level is one, last line is lsb
    function automatic logic [BUS_W-1:0] bus_code(input logic [BUS_W-1:0] v);
        logic [BUS_W-1:0] r;
        r = '0;
        for (int i = 0; i < BUS_W; i++)
            r[i] = ~v[BUS_W-1-i];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic                 reset_s;      // synchronised reset pin, low = reset
    logic                 halt_s;       // synchronised halt pin, low = halt
    logic [BUS_W-1:0]     bus_s;        // synchronised bus lines
    logic [INSTR_W-1:0]   instr_s;      // synchronised instruction lines

    mcpi_sync #(
        .WIDTH (2 + BUS_W + INSTR_W),
        .INIT  ({2'h3, 24'h000000})
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({reset_pin_n, halt_n, peripheral_data_bus_in, instruction_word}),
        .sync_out ({reset_s, halt_s, bus_s, instr_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    logic [1:0]       q_reg;            // quarter of the instruction cycle
    mcpi_state_t      state_reg;        // reset, run or halt
    logic [PC_W-1:0]  pc_reg;           // program counter / address register
    mcpi_op_t         op_reg;           // bus operation of this cycle
    logic [BUS_W-1:0] op_data_reg;      // address or data for the bus
    logic             bank_l_n_reg;     // registered left bank enable
    logic             bank_r_n_reg;     // registered right bank enable
    logic             sc_reg;           // select strobe
    logic             wc_reg;           // write flag
    logic             oe_reg;           // bus drive enable
    logic             mclk_reg;         // master clock
    logic             go_next;          // next cycle executes

    // a new cycle starts at the end of the last quarter unless halted
    assign go_next     = (q_reg == Q_LAST) && reset_s && halt_s;
    assign cycle_start = go_next;
    assign halted      = (state_reg == ST_HALT);

    // quarter counter: four quarters make one instruction cycle
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
            q_reg <= Q_FIRST;
        else
            q_reg <= q_reg + 2'h1;
    end

    // run state: reset at any quarter, run or halt decided at an instruction boundary
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
            state_reg <= ST_RESET;
        else if (q_reg == Q_LAST)
        begin
            if (halt_s)
                state_reg <= ST_RUN;
            else
                state_reg <= ST_HALT;
        end
    end

    // program counter: cleared by reset, frozen while halted
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
            pc_reg <= PC_RESET;
        else if (go_next && state_reg != ST_RESET)
        begin
            if (core_jump)
                pc_reg <= core_jump_addr;
            else
                pc_reg <= pc_reg + 13'h0001;
        end
    end

    // program address pins, first line is the msb
    assign program_address = rev_pc(pc_reg);

    // operation and banks latched for the coming cycle
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
        begin
            op_reg       <= OP_NONE;
            op_data_reg  <= BUS_RESET;
            bank_l_n_reg <= 1'b1;
            bank_r_n_reg <= 1'b1;
        end
        else if (go_next)
        begin
            op_reg       <= core_op;
            op_data_reg  <= core_op_data;
            bank_l_n_reg <= ~core_left;
            bank_r_n_reg <= ~core_right;
        end
        else if (q_reg == Q_LAST)
        begin
            // halt: no bus work, banks high from the first quarter on
            op_reg       <= OP_NONE;
            bank_l_n_reg <= 1'b1;
            bank_r_n_reg <= 1'b1;
        end
    end

    // reset pin forces both banks high without waiting for a clock
    assign left_bank_enable_n  = bank_l_n_reg | ~reset_pin_n;
    assign right_bank_enable_n = bank_r_n_reg | ~reset_pin_n;

    ////////////////////////////////////////////////////////////////////////
    // port bus drive: quarters two to four, so strobes span the master clock

    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
        begin
            sc_reg <= 1'b0;
            wc_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else if (q_reg == Q_FIRST)
        begin
            sc_reg <= (op_reg == OP_SELECT);
            wc_reg <= (op_reg == OP_WRITE);
            oe_reg <= (op_reg == OP_SELECT) || (op_reg == OP_WRITE);
        end
        else if (q_reg == Q_LAST)
        begin
            // release the bus as the master clock falls, ports clock on its high phase
            sc_reg <= 1'b0;
            wc_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
    end

    assign port_select_strobe      = sc_reg;
    assign write_direction_flag    = wc_reg;
    assign peripheral_data_bus_oe  = oe_reg;
    assign peripheral_data_bus_out = bus_code(op_data_reg);

    // read sampling and instruction capture late in the cycle
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
        begin
            read_data   <= BUS_RESET;
            read_valid  <= 1'b0;
            fetch_word  <= '0;
            fetch_valid <= 1'b0;
        end
        else
        begin
            read_valid  <= (q_reg == Q_SAMPLE) && (op_reg == OP_READ);
            fetch_valid <= (q_reg == Q_SAMPLE) && (state_reg == ST_RUN);
            if ((q_reg == Q_SAMPLE) && (op_reg == OP_READ))
                read_data <= bus_code(bus_s);
            if ((q_reg == Q_SAMPLE) && (state_reg == ST_RUN))
                fetch_word <= rev_instr(instr_s);
        end
    end

    // master clock high in the last quarter, stopped under reset
    always_ff @(posedge core_clk)
    begin
        if (rst || !reset_s)
            mclk_reg <= 1'b0;
        else
            mclk_reg <= (q_reg == Q_SAMPLE);
    end

    assign master_clock = mclk_reg;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_select_addr;
        port_select_strobe |-> peripheral_data_bus_oe && (op_reg == OP_SELECT);
    endproperty
    a_select_addr: assert property (p_select_addr)
        else $error("select strobe without address drive");

    property p_write_drive;
        write_direction_flag |-> peripheral_data_bus_oe && !port_select_strobe;
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("write flag without data drive");

    property p_reset_banks;
        !reset_pin_n |-> left_bank_enable_n && right_bank_enable_n;
    endproperty
    a_reset_banks: assert property (p_reset_banks)
        else $error("bank enable low during reset");

    property p_reset_clear;
        !reset_s |=> (pc_reg == PC_RESET) && !master_clock;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear counter or stop clock");

    property p_mclk_period;
        $rose(master_clock) && reset_s ##1 reset_s [*3] |-> ##1 $rose(master_clock);
    endproperty
    a_mclk_period: assert property (p_mclk_period)
        else $error("master clock period not four cycles");

    property p_halt_freeze;
        (state_reg == ST_HALT) && reset_s && !go_next |=> $stable(pc_reg) || !reset_s;
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("counter moved while halted");

    property p_halt_banks;
        (state_reg == ST_HALT) && reset_s |-> left_bank_enable_n && right_bank_enable_n;
    endproperty
    a_halt_banks: assert property (p_halt_banks)
        else $error("bank enable low while halted");

    property p_pc_step;
        go_next && !core_jump && (state_reg != ST_RESET)
            |=> (pc_reg == $past(pc_reg) + 13'h0001);
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("counter did not step by one");

    property p_halt_entry;
        (q_reg == Q_LAST) && reset_s && !halt_s |=> (state_reg == ST_HALT) && !cycle_start;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("halt not taken at cycle boundary");

endmodule

// File: logic/mcpi_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module mcpi_sync
#(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
)
(
    // clock and reset
    input  logic             core_clk,
    input  logic             rst,
    // asynchronous side
    input  logic [WIDTH-1:0] async_in,
    // synchronised side
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;   // first flop, read only by the second

    // two flops in series, nothing taps the first
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stage1_reg <= INIT;
            sync_out   <= INIT;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule

// File: sim/mcpi_port_if_tb.sv
// self-checking testbench of the controller pin interface
`timescale 1ns/1ps
module mcpi_port_if_tb;
    import mcpi_pkg::*;
    logic core_clk, rst, reset_pin_n, halt_n, core_jump, core_left, core_right;
    logic port_select_strobe, write_direction_flag, left_bank_enable_n;
    logic right_bank_enable_n, master_clock, peripheral_data_bus_oe, cycle_start;
    logic fetch_valid, read_valid, halted;
    logic [PC_W-1:0]    program_address, core_jump_addr, pc_now, jaddr;
    logic [INSTR_W-1:0] instruction_word, fetch_word;
    logic [BUS_W-1:0]   bus_wire, dev_out, core_op_data, read_data, bv, a0;
    mcpi_op_t           core_op;
    int miscompares, num_checks, fetch_n, jump_pend, mc, mem_m [512], sel_m [2];
    logic [PC_W-1:0] last_pc;

    mcpi_port_if mcpi_port_if_i (.core_clk(core_clk), .rst(rst),
        .program_address(program_address), .instruction_word(instruction_word),
        .reset_pin_n(reset_pin_n), .halt_n(halt_n),
        .port_select_strobe(port_select_strobe), .write_direction_flag(write_direction_flag),
        .left_bank_enable_n(left_bank_enable_n), .right_bank_enable_n(right_bank_enable_n),
        .peripheral_data_bus_in(bus_wire), .peripheral_data_bus_out(dev_out),
        .peripheral_data_bus_oe(peripheral_data_bus_oe), .master_clock(master_clock),
        .cycle_start(cycle_start), .core_jump(core_jump), .core_jump_addr(core_jump_addr),
        .core_op(core_op), .core_op_data(core_op_data), .core_left(core_left),
        .core_right(core_right), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
        .read_data(read_data), .read_valid(read_valid), .halted(halted));
    mcpi_port_model mcpi_port_model_i (.core_clk(core_clk), .program_address(program_address),
        .instruction_word(instruction_word), .port_select_strobe(port_select_strobe),
        .write_direction_flag(write_direction_flag), .left_bank_enable_n(left_bank_enable_n),
        .right_bank_enable_n(right_bank_enable_n), .master_clock(master_clock),
        .dev_out(dev_out), .dev_oe(peripheral_data_bus_oe), .bus_wire(bus_wire));

    ////////////////////////////////////////////////////////////////////////
    always #50 core_clk = ~core_clk;
    assign pc_now = {<<{program_address}};
    assign bv     = {<<{~bus_wire}};

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick();
        @(negedge core_clk);
    endtask

    // bounded wait on a level, a run-out ends the run
    task automatic wait_for(ref logic s, input int lim);
        for (int i = 0; i <= lim; i++)
        begin
            if (s === 1'b1)
                return;
            tick();
        end
        miscompares++;
        summarize();
    endtask

    // one bus cycle, checked in its master clock quarter against the model
    task automatic op(input mcpi_op_t o, input logic [7:0] d, input logic r);
        int k;
        k = r ? 256 : 0;
        wait_for(cycle_start, 12);
        core_op = o;
        core_op_data = d;
        core_left = !r;
        core_right = r;
        // request taken at the next edge, drop it before the next boundary
        tick();
        core_op = OP_NONE;
        repeat (3) tick();
        check(master_clock, 1);
        check(port_select_strobe, o == OP_SELECT);
        check(write_direction_flag, o == OP_WRITE);
        check({left_bank_enable_n, right_bank_enable_n}, {r, !r});
        check(peripheral_data_bus_oe, o != OP_READ);
        if (o != OP_READ)
            check(bv, d);
        if (o == OP_SELECT)
            sel_m[r] = d;
        if (o == OP_WRITE)
            mem_m[k + sel_m[r]] = d;
        // read_valid flags the result only in this last quarter, read_data holds it until the next read
        if (o == OP_READ)
        begin
            check(read_valid, 1);
            check(read_data, mem_m[k + sel_m[r]]);
        end
    endtask

    // every fetch: word from storage, address sequence
    always @(negedge core_clk)
    begin
        if (fetch_valid === 1'b1)
        begin
            fetch_n++;
            check(fetch_word, {3'h5, program_address} ^ 16'hA5C3);
            if (fetch_n == 1)
                check(pc_now, 0);
            else if (jump_pend != 0 && pc_now === jaddr)
                jump_pend = 0;
            else if (fetch_n > 2 || pc_now != 0)
                check(pc_now, last_pc + 13'h0001);
            last_pc = pc_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 0; rst = 1; reset_pin_n = 1; halt_n = 1; core_jump = 0;
        core_jump_addr = 0; core_op = OP_NONE; core_op_data = 0; core_left = 0;
        core_right = 0; fetch_n = 0; jump_pend = 0; sel_m = '{0, 0};
        void'($urandom(58251));
        repeat (6) tick();
        rst = 0;
        // reset pin in mid access: banks forced high at once, clock stops
        wait_for(cycle_start, 12);
        core_op = OP_SELECT; core_left = 1;
        repeat (2) tick();
        core_op = OP_NONE;
        check(left_bank_enable_n, 0);
        reset_pin_n = 0;
        #1 check(left_bank_enable_n, 1);
        repeat (4) tick();
        mc = 0;
        repeat (12) begin tick(); mc += master_clock; end
        check(mc, 0);
        check({left_bank_enable_n, right_bank_enable_n}, 2'h3);
        reset_pin_n = 1; fetch_n = 0;
        // traffic on both banks, same address reused across banks
        for (int k = 0; k < 8; k++)
        begin
            if (k % 2 == 0)
                a0 = $urandom;
            op(OP_SELECT, a0, k % 2); op(OP_WRITE, $urandom, k % 2);
            op(OP_SELECT, a0 ^ 8'h5A, k % 2); op(OP_WRITE, $urandom, k % 2);
            op(OP_READ, 8'h00, k % 2); op(OP_SELECT, a0, k % 2);
            op(OP_READ, 8'h00, k % 2); op(OP_READ, 8'h00, !(k % 2));
        end
        // jump lands on the requested address
        wait_for(cycle_start, 12);
        jaddr = $urandom; core_jump_addr = jaddr; core_jump = 1; jump_pend = 1;
        tick();
        core_jump = 0;
        repeat (16) tick();
        check(jump_pend, 0);
        // halt: clock runs, nothing moves, banks held high
        halt_n = 0;
        wait_for(halted, 8);
        repeat (3) tick();
        last_pc = pc_now; mc = 0;
        repeat (16)
        begin
            tick();
            mc += master_clock;
            check(cycle_start, 0);
            check({left_bank_enable_n, right_bank_enable_n}, 2'h3);
            check(pc_now, last_pc);
        end
        check(mc, 4);
        halt_n = 1;
        op(OP_READ, 8'h00, 1);
        summarize();
    end
endmodule

// File: sim/mcpi_port_model.sv
// behavioural program storage and a two-bank port peripheral
`timescale 1ns/1ps
module mcpi_port_model
    import mcpi_pkg::*;
(
    // clock
    input  logic               core_clk,
    // program storage side
    input  logic [PC_W-1:0]    program_address,
    output logic [INSTR_W-1:0] instruction_word,
    // port bus side
    input  logic               port_select_strobe,
    input  logic               write_direction_flag,
    input  logic               left_bank_enable_n,
    input  logic               right_bank_enable_n,
    input  logic               master_clock,
    input  logic [BUS_W-1:0]   dev_out,
    input  logic               dev_oe,
    output logic [BUS_W-1:0]   bus_wire
);
    ////////////////////////////////////////////////////////////////////////
    logic [BUS_W-1:0] mem [2][256]; // port storage, index 0 left, 1 right
    logic [BUS_W-1:0] sel [2];      // address each bank last selected
    logic [BUS_W-1:0] last_bus;     // last level seen on the wire
    logic [BUS_W-1:0] bus_val;      // decoded byte on the wire
    logic [BUS_W-1:0] drv_rev;      // read byte, line order reversed
    logic [1:0]       bank_on;      // banks enabled this cycle
    logic             bk;           // bank that answers a read
    logic             drv_on;       // a port drives the wire

    // program word for the pins, lines reversed so the last is lsb
    function automatic logic [INSTR_W-1:0] rom_w(input logic [PC_W-1:0] a);
        return {3'h5, a} ^ 16'hA5C3;
    endfunction
    assign instruction_word = {<<{rom_w(program_address)}};

    ////////////////////////////////////////////////////////////////////////
    // bank decode and read drive, only one bank may answer
    assign bank_on = {~right_bank_enable_n, ~left_bank_enable_n};
    assign bk      = bank_on[1];
    assign drv_on  = !dev_oe && !port_select_strobe && !write_direction_flag
                     && (bank_on == 2'h1 || bank_on == 2'h2);
    assign drv_rev = {<<{mem[bk][sel[bk]]}};
    // released wire shows the inverse of its last level, no pull exists
    assign bus_wire = dev_oe ? dev_out : drv_on ? ~drv_rev : ~last_bus;
    assign bus_val  = {<<{~bus_wire}};

    // latch address on select, store data on write, at master clock
    always @(posedge core_clk)
    begin
        last_bus <= bus_wire;
        for (int b = 0; b < 2; b++)
        begin
            if (master_clock && bank_on[b] && port_select_strobe)
                sel[b] <= bus_val;
            else if (master_clock && bank_on[b] && write_direction_flag)
                mem[b][sel[b]] <= bus_val;
        end
    end

    initial
    begin
        sel[0] = 8'h00;
        sel[1] = 8'h00;
        // ports power up cleared, so an unwritten location reads zero
        for (int b = 0; b < 2; b++)
            for (int a = 0; a < 256; a++)
                mem[b][a] = 8'h00;
    end
endmodule
